// ---- hdl/rapid_count_and_tune_port.sv ----
`timescale 1ns/1ps
module rapid_count_and_tune_port
  import rapid_pkg::*;
#(
  parameter int GATE_MIN_TICKS = GATE_MIN_TICKS_DEF,
  parameter int REF_MAX_TICKS  = REF_MAX_TICKS_DEF
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       rapidCountCmd,
  input  wire logic       rapidTuneCmd,
  input  wire logic       rxValid,
  input  wire logic [7:0] rxData,
  input  wire logic       busAtn,
  input  wire logic       frontKeyPress,
  input  wire logic       sigIn,
  input  wire logic       nrfdIn,
  input  wire logic       ndacIn,
  input  wire logic       specialFnStrobe,
  input  wire logic [7:0] specialFnCode,
  input  wire logic       specialFnZero,
  output logic [7:0]      dioOut,
  output logic            dioOeN,
  output logic            davOut,
  output logic            countModeActive,
  output logic            tuneModeActive,
  output logic            leftDashes,
  output logic            parserEnable,
  output logic [7:0]      rangeValue,
  output logic [7:0]      coarseTune,
  output logic [7:0]      fineTune,
  output logic            tuneApply,
  output logic            readbackValid,
  output logic [7:0]      readbackValue
);

  if (GATE_MIN_TICKS < 1 || GATE_MIN_TICKS > REF_MAX_TICKS ||
      REF_MAX_TICKS > REF_MAX_TICKS_DEF) begin : gLimitCheck
    $error("Gate tick limits out of range");
  end

  localparam logic [REF_CNT_W-1:0] GATE_MIN = REF_CNT_W'(GATE_MIN_TICKS);
  localparam logic [REF_CNT_W-1:0] REF_MAX  = REF_CNT_W'(REF_MAX_TICKS);
  localparam logic [4:0]           DIV_LAST = 5'(REF_DIV - 1);
  localparam logic [2:0]           TUNE_LAST = 3'(TUNE_BYTES - 1);
  localparam logic [1:0]           REC_LAST  = 2'(RECORD_BYTES - 1);

  typedef enum logic [1:0] {CNT_OFF, CNT_ARM, CNT_GATE, CNT_SEND} count_state_t;

  byte_link_if link ();

  // Reference clock divider
  logic [4:0] refDiv, next_refDiv;
  logic       refTick, next_refTick;

  always_comb begin
    next_refTick = 1'b0;
    if (refDiv == DIV_LAST) begin
      next_refDiv  = 5'h00;
      next_refTick = 1'b1;
    end else begin
      next_refDiv = 5'(refDiv + 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      refDiv  <= 5'h00;
      refTick <= 1'b0;
    end else begin
      refDiv  <= next_refDiv;
      refTick <= next_refTick;
    end
  end

  // Mode control, tuning assembly and special functions
  logic        next_countMode;
  logic        next_tuneMode;
  logic        next_leftDashes;
  logic        next_parserEnable;
  logic [2:0]  tuneIdx, next_tuneIdx;
  logic [15:0] stage, next_stage;
  logic [7:0]  next_rangeValue;
  logic [7:0]  next_coarseTune;
  logic [7:0]  next_fineTune;
  logic        next_tuneApply;
  logic        next_readbackValid;
  logic [7:0]  next_readbackValue;

  always_comb begin
    next_countMode     = countModeActive;
    next_tuneMode      = tuneModeActive;
    next_tuneIdx       = tuneIdx;
    next_stage         = stage;
    next_rangeValue    = rangeValue;
    next_coarseTune    = coarseTune;
    next_fineTune      = fineTune;
    next_tuneApply     = 1'b0;
    next_readbackValid = 1'b0;
    next_readbackValue = readbackValue;
    if (rapidCountCmd) begin
      next_countMode = 1'b1;
      next_tuneMode  = 1'b0;
    end else if (rapidTuneCmd) begin
      next_tuneMode  = 1'b1;
      next_countMode = 1'b0;
      next_tuneIdx   = 3'h0;
    end else begin
      if (countModeActive && (rxValid || busAtn)) begin
        next_countMode = 1'b0;
      end
      if (tuneModeActive) begin
        if (frontKeyPress || busAtn) begin
          next_tuneMode = 1'b0;
        end else if (rxValid) begin
          if (rxData[7:4] != TUNE_PREFIX) begin
            next_tuneMode = 1'b0;
          end else if (tuneIdx == TUNE_LAST) begin
            // Whole word lands in one cycle
            next_rangeValue = {4'h0, stage[15:12]};
            next_coarseTune = stage[11:4];
            next_fineTune   = {stage[3:0], rxData[3:0]};
            next_tuneApply  = 1'b1;
            next_tuneMode   = 1'b0;
          end else begin
            next_stage   = {stage[11:0], rxData[3:0]};
            next_tuneIdx = 3'(tuneIdx + 1'b1);
          end
        end
      end
      if (!countModeActive && !tuneModeActive && specialFnStrobe) begin
        unique case (specialFnCode)
          SF_RANGE: begin
            if (specialFnZero) begin
              next_rangeValue = 8'h00;
              next_tuneApply  = 1'b1;
            end else begin
              next_readbackValue = rangeValue;
              next_readbackValid = 1'b1;
            end
          end
          SF_COARSE: begin
            if (specialFnZero) begin
              next_coarseTune = 8'h00;
              next_tuneApply  = 1'b1;
            end else begin
              next_readbackValue = coarseTune;
              next_readbackValid = 1'b1;
            end
          end
          SF_FINE: begin
            if (specialFnZero) begin
              next_fineTune  = 8'h00;
              next_tuneApply = 1'b1;
            end else begin
              next_readbackValue = fineTune;
              next_readbackValid = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end
    next_leftDashes   = next_countMode;
    next_parserEnable = !next_countMode && !next_tuneMode;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      countModeActive <= 1'b0;
      tuneModeActive  <= 1'b0;
      leftDashes      <= 1'b0;
      parserEnable    <= 1'b1;
      tuneIdx         <= 3'h0;
      stage           <= 16'h0000;
      rangeValue      <= 8'h00;
      coarseTune      <= 8'h00;
      fineTune        <= 8'h00;
      tuneApply       <= 1'b0;
      readbackValid   <= 1'b0;
      readbackValue   <= 8'h00;
    end else begin
      countModeActive <= next_countMode;
      tuneModeActive  <= next_tuneMode;
      leftDashes      <= next_leftDashes;
      parserEnable    <= next_parserEnable;
      tuneIdx         <= next_tuneIdx;
      stage           <= next_stage;
      rangeValue      <= next_rangeValue;
      coarseTune      <= next_coarseTune;
      fineTune        <= next_fineTune;
      tuneApply       <= next_tuneApply;
      readbackValid   <= next_readbackValid;
      readbackValue   <= next_readbackValue;
    end
  end

  // Reciprocal counter and record streaming
  count_state_t          cntState, next_cntState;
  logic                  sigPrev;
  logic                  sigRise;
  logic [REF_CNT_W-1:0]  refCount, next_refCount;
  logic [CYC_CNT_W-1:0]  cycCount, next_cycCount;
  logic [CYC_CNT_W-1:0]  cycPlus;
  logic [31:0]           record, next_record;
  logic [1:0]            recIdx, next_recIdx;

  assign sigRise = sigIn && !sigPrev;
  assign cycPlus = CYC_CNT_W'(cycCount + 1'b1);

  always_comb begin
    next_cntState = cntState;
    next_refCount = refCount;
    next_cycCount = cycCount;
    next_record   = record;
    next_recIdx   = recIdx;
    if (!countModeActive) begin
      next_cntState = CNT_OFF;
    end else begin
      unique case (cntState)
        CNT_OFF: begin
          next_cntState = CNT_ARM;
        end
        CNT_ARM: begin
          if (sigRise) begin
            next_refCount = '0;
            next_cycCount = '0;
            next_cntState = CNT_GATE;
          end
        end
        CNT_GATE: begin
          if (refTick) begin
            next_refCount = REF_CNT_W'(refCount + 1'b1);
          end
          if (sigRise && (refCount >= GATE_MIN || cycPlus == CYC_MAX)) begin
            // Gate closes on a whole input cycle
            next_record   = encodeRecord(refCount, cycPlus);
            next_recIdx   = 2'h0;
            next_cntState = CNT_SEND;
          end else if (refCount == REF_MAX) begin
            next_record   = encodeRecord(refCount, cycCount);
            next_recIdx   = 2'h0;
            next_cntState = CNT_SEND;
          end else if (sigRise) begin
            next_cycCount = cycPlus;
          end
        end
        CNT_SEND: begin
          if (link.ready) begin
            next_record = {record[23:0], 8'h00};
            next_recIdx = 2'(recIdx + 1'b1);
            if (recIdx == REC_LAST) begin
              next_cntState = CNT_ARM;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cntState <= CNT_OFF;
      sigPrev  <= 1'b0;
      refCount <= '0;
      cycCount <= '0;
      record   <= 32'h0000_0000;
      recIdx   <= 2'h0;
    end else begin
      cntState <= next_cntState;
      sigPrev  <= sigIn;
      refCount <= next_refCount;
      cycCount <= next_cycCount;
      record   <= next_record;
      recIdx   <= next_recIdx;
    end
  end

  // Only record bytes ever reach the talker
  assign link.valid = (cntState == CNT_SEND);
  assign link.data  = record[31:24];
  assign link.abort = !countModeActive;

  source_handshake uTalker (
    .clk     (clk),
    .sys_rst (sys_rst),
    .link    (link),
    .nrfdIn  (nrfdIn),
    .ndacIn  (ndacIn),
    .dioOut  (dioOut),
    .dioOeN  (dioOeN),
    .davOut  (davOut)
  );

endmodule

// ---- inc/rapid_pkg.sv ----
package rapid_pkg;

  // Core and reference clock rates
  localparam int CLK_FREQ_HZ   = 50_000_000;
  localparam int REF_CLOCK_HZ  = 2_000_000;
  localparam int REF_DIV       = CLK_FREQ_HZ / REF_CLOCK_HZ;

  // Data settle time on the data lines before the data-valid line is asserted
  localparam int DATA_SETTLE_NS = 500;
  localparam int SETTLE_CYCLES  =
    (DATA_SETTLE_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;

  // Record layout
  localparam int RECORD_BYTES  = 4;
  localparam int REF_CNT_W     = 19;
  localparam int CYC_CNT_W     = 12;
  localparam int CLK_HI_SHIFT  = 10;
  localparam int CYC_LO_BITS   = 4;
  localparam int MSD_POS       = 4;
  localparam logic [8:0] CLK_HI_BIAS = 9'h104;
  localparam logic [7:0] CYC_HI_BIAS = 8'hff;

  // Gate limits in reference ticks, and the input cycle count limit
  localparam int GATE_MIN_TICKS_DEF = 5 * 1024;
  localparam int REF_MAX_TICKS_DEF  = 261 * 1024 - 1;
  localparam logic [CYC_CNT_W-1:0] CYC_MAX = 12'hfff;

  // Tuning transfer
  localparam int TUNE_BYTES         = 5;
  localparam logic [3:0] TUNE_PREFIX = 4'h3;

  // Special function codes
  localparam logic [7:0] SF_RANGE  = 8'h37;
  localparam logic [7:0] SF_COARSE = 8'h38;
  localparam logic [7:0] SF_FINE   = 8'h39;

  function automatic logic [31:0] encodeRecord(
    input logic [REF_CNT_W-1:0] clkCount,
    input logic [CYC_CNT_W-1:0] cycCount
  );
    logic [8:0] clkHi;
    logic [8:0] hiByte;
    logic [7:0] cycByte;
    clkHi   = clkCount[REF_CNT_W-1:CLK_HI_SHIFT];
    hiByte  = 9'(CLK_HI_BIAS - clkHi);
    cycByte = 8'(CYC_HI_BIAS - cycCount[CYC_CNT_W-1:CYC_LO_BITS]);
    encodeRecord = {hiByte[7:0],
                    clkCount[3:0], clkCount[7:4],
                    cycByte,
                    2'b00, clkCount[9:8], cycCount[CYC_LO_BITS-1:0]};
  endfunction

endpackage

// ---- inc/byte_link_if.sv ----
`timescale 1ns/1ps
interface byte_link_if;
  logic       valid;
  logic       ready;
  logic       abort;
  logic [7:0] data;

  modport src (output valid, output data, output abort, input ready);
  modport snk (input valid, input data, input abort, output ready);
endinterface

// ---- hdl/source_handshake.sv ----
`timescale 1ns/1ps
module source_handshake
  import rapid_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    sys_rst,
  byte_link_if.snk     link,
  input  wire logic    nrfdIn,
  input  wire logic    ndacIn,
  output logic [7:0]   dioOut,
  output logic         dioOeN,
  output logic         davOut
);

  typedef enum logic [2:0] {SH_IDLE, SH_SETTLE, SH_WAIT_RFD, SH_ACCEPT, SH_RELEASE} sh_state_t;

  sh_state_t   state, next_state;
  logic [7:0]  next_dioOut;
  logic        next_dioOeN;
  logic        next_davOut;
  logic        ready, next_ready;
  logic [5:0]  settle, next_settle;

  assign link.ready = ready;

  always_comb begin
    next_state  = state;
    next_dioOut = dioOut;
    next_dioOeN = dioOeN;
    next_davOut = davOut;
    next_ready  = 1'b0;
    next_settle = settle;
    if (link.abort) begin
      next_state  = SH_IDLE;
      next_dioOeN = 1'b1;
      next_davOut = 1'b0;
    end else begin
      unique case (state)
        SH_IDLE: begin
          if (link.valid) begin
            next_dioOut = link.data;
            next_dioOeN = 1'b0;
            next_settle = 6'(SETTLE_CYCLES - 1);
            next_state  = SH_SETTLE;
          end
        end
        SH_SETTLE: begin
          if (settle == 6'h00) begin
            next_state = SH_WAIT_RFD;
          end else begin
            next_settle = 6'(settle - 1'b1);
          end
        end
        SH_WAIT_RFD: begin
          if (!nrfdIn && ndacIn) begin
            next_davOut = 1'b1;
            next_state  = SH_ACCEPT;
          end
        end
        SH_ACCEPT: begin
          if (!ndacIn) begin
            next_davOut = 1'b0;
            next_ready  = 1'b1;
            next_state  = SH_RELEASE;
          end
        end
        SH_RELEASE: begin
          if (ndacIn) begin
            next_state = SH_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state  <= SH_IDLE;
      dioOut <= 8'h00;
      dioOeN <= 1'b1;
      davOut <= 1'b0;
      ready  <= 1'b0;
      settle <= 6'h00;
    end else begin
      state  <= next_state;
      dioOut <= next_dioOut;
      dioOeN <= next_dioOeN;
      davOut <= next_davOut;
      ready  <= next_ready;
      settle <= next_settle;
    end
  end

endmodule

// ---- tb/rapid_port_chk.sv ----
`timescale 1ns/1ps
module rapid_port_chk
  import rapid_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       rapidCountCmd,
  input wire logic       rapidTuneCmd,
  input wire logic       rxValid,
  input wire logic       busAtn,
  input wire logic       frontKeyPress,
  input wire logic       nrfdIn,
  input wire logic       ndacIn,
  input wire logic       specialFnStrobe,
  input wire logic [7:0] specialFnCode,
  input wire logic       specialFnZero,
  input wire logic [7:0] dioOut,
  input wire logic       dioOeN,
  input wire logic       davOut,
  input wire logic       countModeActive,
  input wire logic       tuneModeActive,
  input wire logic       leftDashes,
  input wire logic       parserEnable,
  input wire logic [7:0] rangeValue,
  input wire logic [7:0] coarseTune,
  input wire logic       tuneApply,
  input wire logic       readbackValid,
  input wire logic [7:0] readbackValue
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire anyCmd = rapidCountCmd || rapidTuneCmd;

  a_dash_mirror: assert property (leftDashes == countModeActive)
    else $error("dash indication differs from count mode");
  a_parser_idle: assert property (parserEnable == !(countModeActive || tuneModeActive))
    else $error("parser enable wrong");
  a_tune_entry: assert property (rapidTuneCmd && !rapidCountCmd |=> tuneModeActive)
    else $error("tune mode not entered");
  a_tune_abort: assert property (
    tuneModeActive && (busAtn || frontKeyPress) && !anyCmd |=> !tuneModeActive)
    else $error("tune mode not aborted");
  a_count_exit: assert property (
    countModeActive && (rxValid || busAtn) && !rapidCountCmd |=> !countModeActive)
    else $error("count mode not ended");
  a_dav_ready: assert property (
    $rose(davOut) |-> $past(nrfdIn) == 1'b0 && $past(ndacIn) == 1'b1)
    else $error("data valid before listeners ready");
  a_dav_release: assert property (davOut && !ndacIn |=> !davOut)
    else $error("data valid held after accept");
  a_data_hold: assert property (davOut && $past(davOut) |-> dioOut == $past(dioOut))
    else $error("data changed under data valid");
  a_drive_dav: assert property (davOut |-> !dioOeN)
    else $error("data valid without driving");
  a_exit_release: assert property (
    $fell(countModeActive) |-> ##[0:1] (!davOut && dioOeN))
    else $error("bus not released on exit");
  a_no_partial: assert property (
    tuneApply |-> $past(specialFnStrobe) ||
      ($past(tuneModeActive) && $past(rxValid) && !$past(busAtn) && !$past(frontKeyPress)))
    else $error("settings applied without cause");
  a_range_read: assert property (
    specialFnStrobe && !specialFnZero && specialFnCode == SF_RANGE && parserEnable
    |=> readbackValid && readbackValue == rangeValue)
    else $error("range readback wrong");
  a_zero_force: assert property (
    specialFnStrobe && specialFnZero && specialFnCode == SF_COARSE && parserEnable
    |=> coarseTune == 8'h00 && tuneApply)
    else $error("coarse not forced to zero");
endmodule

bind rapid_count_and_tune_port rapid_port_chk chk (.*);

// ---- tb/bus_listener.sv ----
`timescale 1ns/1ps
module bus_listener (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] dioOut,
  input  wire logic       davOut,
  input  wire logic [3:0] lag,
  output logic            nrfd,
  output logic            ndac,
  output logic            got,
  output logic [7:0]      byteSeen
);
  logic [3:0] holdOff;
  always @(posedge clk) begin
    got <= 1'b0;
    if (sys_rst) begin
      nrfd <= 1'b1;
      ndac <= 1'b1;
      holdOff <= 4'h0;
    end else if (holdOff != 4'h0) begin
      holdOff <= holdOff - 4'h1;
    end else if (davOut && ndac) begin
      byteSeen <= dioOut;
      got <= 1'b1;
      ndac <= 1'b0;
      nrfd <= 1'b1;
      holdOff <= lag;
    end else if (!davOut && !ndac) begin
      ndac <= 1'b1;
      holdOff <= lag;
    end else if (!davOut) begin
      nrfd <= 1'b0;
    end
  end
endmodule

// ---- tb/tb_rapid_count_and_tune_port.sv ----
`timescale 1ns/1ps
module tb_rapid_count_and_tune_port;
  import rapid_pkg::*;
  logic       clk = 0, sys_rst = 1, rapidCountCmd = 0, rapidTuneCmd = 0;
  logic       rxValid = 0, busAtn = 0, frontKeyPress = 0, sigIn = 0;
  logic       specialFnStrobe = 0, specialFnZero = 0;
  logic [7:0] rxData = 8'h00, specialFnCode = 8'h00;
  logic [7:0] dioOut, rangeValue, coarseTune, fineTune, readbackValue, byteSeen;
  logic       dioOeN, davOut, countModeActive, tuneModeActive, leftDashes;
  logic       parserEnable, tuneApply, readbackValid, nrfdIn, ndacIn, got;
  logic [3:0] lag = 4'h0;
  logic [7:0] rec [8];
  int         nBytes = 0, nApply = 0, ph = 0, nErrors = 0, samplesChecked = 0;

  always #10 clk = ~clk;

  rapid_count_and_tune_port #(.GATE_MIN_TICKS(40), .REF_MAX_TICKS(400)) dut (.*);
  bus_listener lsn (.nrfd(nrfdIn), .ndac(ndacIn), .*);

  always @(posedge clk) begin
    ph <= (ph == 99) ? 0 : ph + 1;
    sigIn <= (ph < 50);
    if (got && nBytes < 8) rec[nBytes] <= byteSeen;
    if (got) nBytes <= nBytes + 1;
    if (tuneApply === 1'b1) nApply <= nApply + 1;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nErrors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Pulse one control input for one cycle: 0 count, 1 tune, 2 attention, 3 key
  task automatic hit(input int which);
    @(posedge clk);
    case (which)
      0: rapidCountCmd <= 1'b1;
      1: rapidTuneCmd <= 1'b1;
      2: busAtn <= 1'b1;
      default: frontKeyPress <= 1'b1;
    endcase
    @(posedge clk);
    {rapidCountCmd, rapidTuneCmd, busAtn, frontKeyPress} <= 4'h0;
  endtask

  task automatic sendBytes(input logic [7:0] b [5], input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rxValid <= 1'b1;
      rxData <= b[i];
    end
    @(posedge clk);
    rxValid <= 1'b0;
  endtask

  task automatic conclude;
    $display("checked %0d, mismatches %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic t_reset;
    @(negedge clk);
    check("oe after reset", dioOeN, 1);
    check("parser after reset", parserEnable, 1);
    check("modes after reset", {countModeActive, tuneModeActive, davOut}, 0);
    check("range after reset", rangeValue, 0);
    $display("test reset done");
  endtask

  task automatic t_tune;
    hit(1);
    @(negedge clk);
    check("tune entered", {tuneModeActive, parserEnable}, 2'b10);
    sendBytes('{8'h31, 8'h39, 8'h33, 8'h38, 8'h30}, 5);
    @(negedge clk);
    check("tune apply", tuneApply, 1);
    check("tuned word", {rangeValue, coarseTune, fineTune}, 24'h01_9380);
    check("tune done", tuneModeActive, 0);
    $display("test tune done");
  endtask

  task automatic t_abort;
    for (int k = 0; k < 3; k++) begin
      hit(1);
      sendBytes('{8'h3f, 8'h3e, 8'h41, 8'h30, 8'h30}, (k == 2) ? 3 : 2);
      if (k < 2) hit(k + 2);
      @(negedge clk);
      check("tune aborted", tuneModeActive, 0);
    end
    check("partial discarded", {rangeValue, coarseTune, fineTune}, 24'h01_9380);
    check("apply count", nApply, 1);
    $display("test abort done");
  endtask

  task automatic t_special;
    logic [7:0]  codes [6];
    logic [23:0] vals [6];
    codes = '{SF_RANGE, SF_COARSE, SF_FINE, SF_COARSE, SF_RANGE, SF_FINE};
    vals = '{24'h00_0001, 24'h00_0093, 24'h00_0080, 24'h01_0080, 24'h00_0080, 24'h00_0000};
    // Read all three settings back, then zero them one at a time
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      specialFnStrobe <= 1'b1;
      specialFnCode <= codes[i];
      specialFnZero <= (i >= 3);
      @(posedge clk);
      specialFnStrobe <= 1'b0;
      @(negedge clk);
      if (i < 3) begin
        check("readback", {readbackValid, readbackValue}, {1'b1, vals[i][7:0]});
      end else begin
        check("zeroed", {tuneApply, rangeValue, coarseTune, fineTune}, {1'b1, vals[i]});
      end
    end
    $display("test special done");
  endtask

  task automatic t_count;
    int c;
    int n;
    hit(0);
    @(negedge clk);
    check("count entered", {countModeActive, leftDashes, parserEnable}, 3'b110);
    for (int i = 0; i < 20000 && nBytes < 8; i++) begin
      @(posedge clk);
      if (nBytes >= 4) lag <= 4'h6;
    end
    for (int r = 0; r < 8; r += 4) begin
      c = {rec[r+3][5:4], rec[r+1][3:0], rec[r+1][7:4]} + 1024 * ((260 - rec[r]) & 255);
      check("clock count", (c >= 39 && c <= 41), 1);
      check("cycle high", rec[r+2], 8'hff);
      check("cycle low", rec[r+3] & 8'h0f, 8'h0a);
    end
    @(posedge clk);
    rxValid <= 1'b1;
    rxData <= 8'h3f;
    @(posedge clk);
    rxValid <= 1'b0;
    @(negedge clk);
    check("count ended", countModeActive, 0);
    @(negedge clk);
    check("bus released", {dioOeN, davOut, parserEnable}, 3'b101);
    n = nBytes;
    repeat (300) @(posedge clk);
    check("no bytes after exit", nBytes, n);
    $display("test count done");
  endtask

  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_tune();
    t_abort();
    t_special();
    t_count();
    conclude();
  end

  initial begin
    repeat (60000) @(posedge clk);
    nErrors++;
    conclude();
  end
endmodule
